/* File: tw_consts.svh */
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH
// System clock period in ns
`define PCLK_NS         20
// Bus timing figures in ns
`define T_LOW_NS        1300
`define T_HIGH_NS       600
// Quarter bit period, rounded up so the low phase is never short
`define SCL_QTR_CYC     ((`T_LOW_NS + 2 * `PCLK_NS - 1) / (2 * `PCLK_NS))
// Slave address and direction encoding
`define SLAVE_ADDR      7'h44
`define DIR_READ        1'b1
// Device register map
`define REG_CTRL        8'h00
`define REG_LVL_A       8'h08
`define REG_LVL_B       8'h09
`define REG_LVL_C       8'h0A
`define REG_LVL_D       8'h0B
`define REG_APPLIED     8'h0F
`define CTRL_RANGE_BIT  2
`define CTRL_MASK       8'h0F
`define LVL_OVR_BIT     7
`define CTRL_RESET      8'h00
`define LVL_RESET       8'h00
// Built-in levels, one code step per mVpp
`define DEF_LVL_A       7'h0F
`define DEF_LVL_B       7'h12
`define DEF_LVL_C       7'h1A
`define DEF_LVL_D       7'h1A
// Controller register map on APB
`define APB_CMD         12'h000
`define APB_STATUS      12'h004
`define CMD_RW_BIT      16
`define STAT_BUSY_BIT   0
`define STAT_NACK_BIT   1
`endif

/* File: tw_pkg.sv */
`default_nettype none
package tw_pkg;
   // Device protocol phase
   typedef enum logic [2:0] {
      D_IDLE, D_ADDR, D_REG, D_DATA, D_DONE
   } dev_phase_t;
   // Controller sequencer phase
   typedef enum logic [1:0] {
      M_IDLE, M_START, M_BITS, M_STOP
   } mst_phase_t;
   // Device state
   typedef struct packed {
      dev_phase_t      phase;
      logic [3:0]      cnt;
      logic [7:0]      shreg;
      logic            rw;
      logic [7:0]      ptr;
      logic            sda_oe;
      logic            scl_p;
      logic            sda_p;
      logic [7:0]      ctrl;
      logic [3:0][7:0] lvl;
      logic [6:0]      applied;
      logic            no_signal;
   } dev_state_t;
   // Controller state
   typedef struct packed {
      mst_phase_t  phase;
      logic [6:0]  qcnt;
      logic [1:0]  q;
      logic [1:0]  byte_n;
      logic [3:0]  bit_n;
      logic [7:0]  wdata;
      logic [7:0]  regad;
      logic        rw;
      logic [7:0]  shreg;
      logic        nack;
      logic        scl_oe;
      logic        sda_oe;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } mst_state_t;
endpackage
`default_nettype wire

/* File: tw_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Open-drain two-wire bus with pull-ups on both lines
interface tw_if;
   logic m_scl_oe;  // Controller pulls clock low
   logic m_sda_oe;  // Controller pulls data low
   logic s_sda_oe;  // Device pulls data low
   logic scl;       // Resolved clock level
   logic sda;       // Resolved data level
   assign scl = ~m_scl_oe;
   assign sda = ~(m_sda_oe | s_sda_oe);
   modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
   modport slave  (output s_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

/* File: tw_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for levels from outside the pclk domain
module tw_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;    // First stage, read only by second
      logic [W-1:0] stable;  // Second stage
   } sync_state_t;
   sync_state_t r;
   sync_state_t next_r;

   // Shift one stage per clock
   always_comb begin
      next_r.meta   = d;
      next_r.stable = r.meta;
   end

   // Register the state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.stable;
endmodule
`default_nettype wire

/* File: tw_device.sv */
// Operation
// [RULE1] Flag asserts while peak below selected threshold
// [RULE2] Range bit picks high or low level set
// [RULE3] Seven-bit code gives 128 levels per range
// [RULE4] Speed pins pick one of four level registers
// [RULE5] Override bit picks code, else built-in level
// [RULE6] Floating pins select the fourth level register
// [RULE7] Bus writes and reads the register map
// [RULE8] Device is slave only, clocked by master
// [RULE9] Master makes clock, START and STOP
// [RULE10] START, address+dir, register, data, STOP
// [RULE11] Direction bit zero writes, one reads
// [RULE12] Both lines high means bus idle
// [RULE13] Data falling with clock high is START
// [RULE14] Data rising with clock high is STOP
// [RULE15] Repeated START begins a new transfer
// [RULE16] One data byte per transfer
// [RULE17] Receiver pulls data low during acknowledge; the master releases data in the acknowledge slot after a read data byte
// [RULE18] Unaddressed slave leaves data high
// [RULE19] Master stops after data byte not acknowledged
// [RULE20] Clock at most 400 kHz, minimum phases
// [RULE21] Register 15 reads applied level code
// [RULE22] Write lands after byte acknowledged, unmapped ignored
// [RULE23] Read shifts register out MSB first
`timescale 1ns/10ps
`default_nettype none
`include "tw_consts.svh"
module tw_device (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Two-wire bus
   tw_if.slave             bus,
   // Speed select pins, driven high/low when left open
   input  wire logic       speed_select_msb,
   input  wire logic       speed_select_lsb,
   // Peak detector amplitude code
   input  wire logic [7:0] peak_level,
   // Status outputs
   output logic            no_signal_flag,
   output logic      [6:0] applied_level_readback
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   tw_pkg::dev_state_t r;       // Present state
   tw_pkg::dev_state_t next_r;  // Next state
   logic [11:0]        pins;    // Synchronised pin levels
   logic               scl_s;   // Clock level
   logic               sda_s;   // Data level
   logic [1:0]         sel;     // Selected level register
   logic [7:0]         sel_reg; // Contents of the selected register
   logic               rise;    // Clock rising
   logic               fall;    // Clock falling
   logic               start;   // START seen
   logic               stop;    // STOP seen

   ////////////////////////////////////////////////////////////////////////
   // Built-in level for each register slot
   function automatic logic [6:0] default_level(input logic [1:0] idx);
      logic [6:0] v;
      unique case (idx)
         2'h0: v = `DEF_LVL_A;
         2'h1: v = `DEF_LVL_B;
         2'h2: v = `DEF_LVL_C;
         2'h3: v = `DEF_LVL_D;
      endcase
      return v;
   endfunction

   // Register read data; unmapped addresses read zero
   function automatic logic [7:0] read_reg(input tw_pkg::dev_state_t s);
      logic [7:0] v;
      v = 8'h00;
      unique case (s.ptr)
         `REG_CTRL:    v = s.ctrl;
         `REG_LVL_A,
         `REG_LVL_B,
         `REG_LVL_C,
         `REG_LVL_D:   v = s.lvl[s.ptr[1:0]];
         `REG_APPLIED: v = {1'b0, s.applied}; // [RULE21]
         default:      v = 8'h00;
      endcase
      return v;
   endfunction

   // Amplitude comparison against the full threshold
   function automatic logic peak_level_below(input logic [7:0] pk,
                                             input logic [7:0] th);
      return pk < th;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Every outside level passes two flops before use
   tw_sync #(
      .W (12)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({peak_level, speed_select_msb, speed_select_lsb,
                 bus.sda, bus.scl}),
      .q       (pins)
   );

   assign scl_s = pins[0];
   assign sda_s = pins[1];

   ////////////////////////////////////////////////////////////////////////
   // Level selection and bus event detection
   always_comb begin
      // Pins 00,01,11,10 map to slots 0,1,2,3
      sel     = {pins[3], pins[3] ^ pins[2]}; // [RULE4] [RULE6]
      sel_reg = r.lvl[sel];
      // Edges are taken against the synchronised previous sample
      rise    = scl_s & ~r.scl_p;
      fall    = ~scl_s & r.scl_p;
      start   = scl_s & r.scl_p & r.sda_p & ~sda_s; // [RULE13] [RULE15]
      stop    = scl_s & r.scl_p & ~r.sda_p & sda_s; // [RULE14] [RULE12]
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state: protocol engine, register file, level logic
   always_comb begin
      next_r       = r;
      next_r.scl_p = scl_s;
      next_r.sda_p = sda_s;

      // Applied code: override flag chooses programmed code
      if (sel_reg[`LVL_OVR_BIT]) begin
         next_r.applied = sel_reg[6:0]; // [RULE5] [RULE3]
      end else begin
         next_r.applied = default_level(sel); // [RULE5]
      end
      // Range bit forms the top of the threshold, so high range
      // thresholds sit above every low range one
      next_r.no_signal = peak_level_below(pins[11:4], // [RULE1] [RULE2]
                         {r.ctrl[`CTRL_RANGE_BIT], r.applied});

      // The device only follows edges that the master makes
      if (start) begin
         // A START aborts anything in flight, repeated or not
         next_r.phase  = tw_pkg::D_ADDR; // [RULE15] [RULE10]
         next_r.cnt    = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop) begin
         next_r.phase  = tw_pkg::D_IDLE; // [RULE14]
         next_r.sda_oe = 1'b0;
      end else if (r.phase != tw_pkg::D_IDLE &&
                   r.phase != tw_pkg::D_DONE) begin // [RULE8]
         // Sample on rising clock; acknowledge bit not shifted
         if (rise && r.cnt != 4'h9) begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt != 4'h8 &&
                !(r.phase == tw_pkg::D_DATA && r.rw)) begin
               next_r.shreg = {r.shreg[6:0], sda_s};
            end
         end
         // Drive changes only while the clock is low
         if (fall) begin
            if (r.cnt == 4'h8) begin
               unique case (r.phase)
                  tw_pkg::D_ADDR: begin
                     if (r.shreg[7:1] == `SLAVE_ADDR) begin
                        next_r.rw     = r.shreg[0]; // [RULE11]
                        next_r.sda_oe = 1'b1; // [RULE17]
                     end else begin
                        // Not ours: keep data released
                        next_r.phase = tw_pkg::D_IDLE; // [RULE18]
                     end
                  end
                  tw_pkg::D_REG: begin
                     next_r.ptr    = r.shreg;
                     next_r.sda_oe = 1'b1; // [RULE17]
                  end
                  default: begin
                     // Write: acknowledge; read: leave it to master
                     next_r.sda_oe = ~r.rw; // [RULE17]
                  end
               endcase
            end else if (r.cnt == 4'h9) begin
               // End of acknowledge pulse
               next_r.sda_oe = 1'b0;
               next_r.cnt    = 4'h0;
               unique case (r.phase)
                  tw_pkg::D_ADDR: begin
                     next_r.phase = tw_pkg::D_REG;
                  end
                  tw_pkg::D_REG: begin
                     next_r.phase = tw_pkg::D_DATA;
                     if (r.rw) begin
                        // Load and present the first bit at once
                        next_r.shreg  = read_reg(r); // [RULE7]
                        next_r.sda_oe = ~next_r.shreg[7]; // [RULE23]
                     end
                  end
                  default: begin
                     // Commit only now that the byte is acknowledged
                     if (!r.rw) begin
                        unique case (r.ptr)
                           `REG_CTRL: begin
                              next_r.ctrl = r.shreg & `CTRL_MASK; // [RULE22]
                           end
                           `REG_LVL_A,
                           `REG_LVL_B,
                           `REG_LVL_C,
                           `REG_LVL_D: begin
                              next_r.lvl[r.ptr[1:0]] = r.shreg; // [RULE22]
                           end
                           default: begin
                              // Unmapped or read-only: nothing changes
                              next_r.ctrl = r.ctrl; // [RULE22]
                           end
                        endcase
                     end
                     // A second data byte is never acknowledged
                     next_r.phase = tw_pkg::D_DONE; // [RULE16]
                  end
               endcase
            end else if (r.phase == tw_pkg::D_DATA && r.rw) begin
               // Next bit of read data, most significant first
               next_r.shreg  = {r.shreg[6:0], 1'b0};
               next_r.sda_oe = ~r.shreg[6]; // [RULE23]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register the whole state; the level registers start at zero so
   // that the built-in levels govern until software overrides them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r           <= '0;
         r.phase     <= tw_pkg::D_IDLE;
         r.scl_p     <= 1'b1;
         r.sda_p     <= 1'b1;
         r.ctrl      <= `CTRL_RESET;
         r.lvl       <= {4{`LVL_RESET}};
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs come straight from state flops
   assign bus.s_sda_oe           = r.sda_oe;
   assign no_signal_flag         = r.no_signal;
   assign applied_level_readback = r.applied;
endmodule
`default_nettype wire

/* File: tw_master.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tw_consts.svh"
module tw_master (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave port
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Two-wire bus
   tw_if.master             bus
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   tw_pkg::mst_state_t r;      // Present state
   tw_pkg::mst_state_t next_r; // Next state
   logic               sda_s;  // Synchronised data level
   logic               tick;   // Quarter-bit enable
   logic               rd_in;  // Device is sending this byte
   logic [7:0]         txb;    // Byte being sent

   // Data line sampled like any outside pin
   tw_sync #(
      .W (1)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (bus.sda),
      .q       (sda_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_r         = r;
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;
      tick  = (r.qcnt == 7'(`SCL_QTR_CYC - 1)); // [RULE20]
      rd_in = (r.byte_n == 2'h2) && r.rw;
      unique case (r.byte_n)
         2'h0:    txb = {`SLAVE_ADDR, r.rw}; // [RULE10] [RULE11]
         2'h1:    txb = r.regad;
         default: txb = r.wdata;
      endcase

      // Setup cycle: prepare answer, ready in the access cycle
      if (psel && !penable) begin
         next_r.pready = 1'b1;
         next_r.prdata = 32'h0000_0000;
         if (paddr == `APB_STATUS) begin
            next_r.prdata[15:8]           = r.shreg;
            next_r.prdata[`STAT_NACK_BIT] = r.nack;
            next_r.prdata[`STAT_BUSY_BIT] = (r.phase != tw_pkg::M_IDLE);
         end else if (paddr != `APB_CMD) begin
            next_r.pslverr = 1'b1;
         end
      end
      // Command write lands at the completing edge; ignored while busy
      if (psel && penable && r.pready && pwrite && paddr == `APB_CMD &&
          r.phase == tw_pkg::M_IDLE) begin
         next_r.wdata  = pwdata[7:0];
         next_r.regad  = pwdata[15:8];
         next_r.rw     = pwdata[`CMD_RW_BIT];
         next_r.nack   = 1'b0;
         next_r.phase  = tw_pkg::M_START; // [RULE9]
         next_r.q      = 2'h0;
         next_r.qcnt   = 7'h00;
         next_r.byte_n = 2'h0;
         next_r.bit_n  = 4'h0;
      end else if (r.phase != tw_pkg::M_IDLE) begin
         next_r.qcnt = tick ? 7'h00 : r.qcnt + 7'h01;
         if (tick) begin
            next_r.q = r.q + 2'h1;
            unique case (r.phase)
               tw_pkg::M_START: begin
                  if (r.q == 2'h3) begin
                     next_r.phase = tw_pkg::M_BITS;
                  end
               end
               tw_pkg::M_BITS: begin
                  // Sample in the middle of the high phase
                  if (r.q == 2'h2) begin
                     if (r.bit_n != 4'h8 && rd_in) begin
                        next_r.shreg = {r.shreg[6:0], sda_s};
                     end else if (r.bit_n == 4'h8 && !rd_in && sda_s) begin
                        next_r.nack = 1'b1; // [RULE18]
                     end
                  end
                  if (r.q == 2'h3) begin
                     if (r.bit_n != 4'h8) begin
                        next_r.bit_n = r.bit_n + 4'h1;
                     end else if (r.nack || r.byte_n == 2'h2) begin
                        next_r.phase = tw_pkg::M_STOP; // [RULE19] [RULE16]
                     end else begin
                        next_r.byte_n = r.byte_n + 2'h1;
                        next_r.bit_n  = 4'h0;
                     end
                  end
               end
               default: begin
                  if (r.q == 2'h3) begin
                     next_r.phase = tw_pkg::M_IDLE;
                  end
               end
            endcase
         end
      end

      // Line drive from the coming phase and quarter
      unique case (next_r.phase)
         tw_pkg::M_START: begin
            next_r.scl_oe = 1'b0;
            next_r.sda_oe = next_r.q[1]; // [RULE13]
         end
         tw_pkg::M_BITS: begin
            // Clock low for two quarters, high for two
            next_r.scl_oe = ~next_r.q[1]; // [RULE20]
            // Data changes a quarter after the clock falls
            if (next_r.q == 2'h1 && tick) begin
               // Release for acknowledge and for incoming data
               if (next_r.bit_n == 4'h8 || rd_in) begin
                  next_r.sda_oe = 1'b0; // [RULE17]
               end else begin
                  next_r.sda_oe = ~txb[3'(4'h7 - next_r.bit_n)];
               end
            end
         end
         tw_pkg::M_STOP: begin
            next_r.scl_oe = ~next_r.q[1];
            if (next_r.q == 2'h1 && tick) begin
               next_r.sda_oe = 1'b1;
            end else if (next_r.q == 2'h3 && tick) begin
               next_r.sda_oe = 1'b0; // [RULE14]
            end
         end
         default: begin
            next_r.scl_oe = 1'b0; // [RULE12]
            next_r.sda_oe = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register the whole state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r       <= '0;
         r.phase <= tw_pkg::M_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // Outputs come straight from state flops
   assign bus.m_scl_oe = r.scl_oe;
   assign bus.m_sda_oe = r.sda_oe;
   assign prdata       = r.prdata;
   assign pready       = r.pready;
   assign pslverr      = r.pslverr;
endmodule
`default_nettype wire

/* File: tw_link_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the shared two-wire link between controller and device
module tw_link_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link enables and resolved levels
   input wire logic m_scl_oe,
   input wire logic m_sda_oe,
   input wire logic s_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_q;  // Clock level one cycle back
   logic [6:0] run;    // Samples spent at the current clock level
   logic [4:0] edges;  // Clock rises since the last START

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////
   // Phase length and bit position trackers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         run   <= 7'h00;
         edges <= 5'h00;
      end else begin
         scl_q <= scl;
         // Saturate so a long idle never wraps back to a short count
         if (scl != scl_q) begin
            run <= 7'h01;
         end else if (run != 7'h7F) begin
            run <= run + 7'h01;
         end
         if (scl && $fell(sda)) begin
            edges <= 5'h00;
         end else if (scl && !scl_q) begin
            edges <= edges + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus conditions
   sequence start_s;
      scl && $fell(sda);
   endsequence
   sequence stop_s;
      scl && $rose(sda);
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Checks
   dev_no_start_a: assert property ($rose(s_sda_oe) |-> !scl)
      else $error("device pulled data while clock high");
   dev_hold_a: assert property (
      scl && scl_q |-> $stable(s_sda_oe))
      else $error("device data moved in clock high phase");
   dev_slot_a: assert property (
      $rose(s_sda_oe) |-> edges inside {8, 17, [18:26]})
      else $error("device pulled data outside its slots");
   scl_low_min_a: assert property (scl && !scl_q |-> run >= 7'h41)
      else $error("clock low phase too short");
   scl_high_min_a: assert property (
      !scl && scl_q |-> run >= 7'h1E)
      else $error("clock high phase too short");
   bit_count_a: assert property (stop_s |-> edges == 5'h1C)
      else $error("wrong clock count in transfer");
   start_hold_a: assert property (start_s |=> (scl && !sda) [*8])
      else $error("start not held");
   stop_idle_a: assert property (stop_s |=> (scl && sda) [*8])
      else $error("bus not idle after stop");
endmodule
`default_nettype wire

/* File: tb_two_wire_ctrl_los_level_select.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_two_wire_ctrl_los_level_select;
   // Clock, reset, APB
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   // Device side pins
   logic        speed_select_msb;
   logic        speed_select_lsb;
   logic [7:0]  peak_level;
   logic        no_signal_flag;
   logic [6:0]  applied_level_readback;
   // Bookkeeping
   int          mismatches = 0;
   int          n_tests    = 0;
   int          cycles     = 0;

   tw_if bus ();
   tw_master u_tw_master (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
   tw_device u_tw_device (.pclk(pclk), .presetn(presetn), .bus(bus),
      .speed_select_msb(speed_select_msb),
      .speed_select_lsb(speed_select_lsb), .peak_level(peak_level),
      .no_signal_flag(no_signal_flag),
      .applied_level_readback(applied_level_readback));
   tw_link_sva u_tw_link_sva (.pclk(pclk), .presetn(presetn),
      .m_scl_oe(bus.m_scl_oe), .m_sda_oe(bus.m_sda_oe),
      .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; eight transfers need well under the ceiling
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Let level inputs pass the synchronisers and registered stages
   task automatic settle();
      repeat (8) @(posedge pclk);
   endtask
   // One APB transfer; extra edge so the next setup never collides
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Launch a link transfer and poll status until the link is quiet
   task automatic xfer(input logic rd, input logic [7:0] ra,
                       input logic [7:0] wd, output logic [7:0] q);
      logic [31:0] r;
      logic        e;
      apb(1'b1, 12'h000, {15'h0000, rd, ra, wd}, r, e);
      r = 32'h00000001;
      while (r[0] !== 1'b0) apb(1'b0, 12'h004, 32'h00000000, r, e);
      `CHK(r[1], 1'b0)
      q = r[15:8];
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_pins();
      logic [6:0] dflt [4] = '{7'h0F, 7'h12, 7'h1A, 7'h1A};
      `CHK(applied_level_readback, 7'h1A)
      for (int i = 0; i < 4; i++) begin
         {speed_select_msb, speed_select_lsb} <= i[1:0];
         settle();
         `CHK(applied_level_readback, dflt[i])
      end
      {speed_select_msb, speed_select_lsb} <= 2'b10;
      settle();
   endtask
   task automatic t_override();
      logic [7:0] q;
      xfer(1'b0, 8'h0B, 8'hFF, q);
      settle();
      `CHK(applied_level_readback, 7'h7F)
      xfer(1'b1, 8'h0B, 8'h00, q);
      `CHK(q, 8'hFF)
      xfer(1'b1, 8'h0F, 8'h00, q);
      `CHK(q, 8'h7F)
      // Unmapped and read-only targets must not disturb anything
      xfer(1'b0, 8'h05, 8'h00, q);
      xfer(1'b0, 8'h0F, 8'h00, q);
      settle();
      `CHK(applied_level_readback, 7'h7F)
      {speed_select_msb, speed_select_lsb} <= 2'b00;
      settle();
      `CHK(applied_level_readback, 7'h0F)
      {speed_select_msb, speed_select_lsb} <= 2'b10;
      settle();
   endtask
   // Threshold sits at the top code, probed one step below it and at it
   task automatic t_flag();
      logic [7:0] q;
      for (int r = 0; r < 2; r++) begin
         xfer(1'b0, 8'h00, {5'h1E, r[0], 2'b00}, q);
         peak_level <= {r[0], 7'h7E};
         settle();
         `CHK(no_signal_flag, 1'b1)
         peak_level <= {r[0], 7'h7F};
         settle();
         `CHK(no_signal_flag, 1'b0)
      end
      xfer(1'b1, 8'h00, 8'h00, q);
      `CHK(q, 8'h04)
   endtask
   task automatic t_apb();
      logic [31:0] r;
      logic        e;
      apb(1'b0, 12'h008, 32'h00000000, r, e);
      `CHK(e, 1'b1)
      `CHK(r, 32'h00000000)
      apb(1'b0, 12'h000, 32'h00000000, r, e);
      `CHK(r, 32'h00000000)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence; pins start as if left open
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      speed_select_msb = 1'b1;
      speed_select_lsb = 1'b0;
      peak_level = 8'hFF;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      t_pins();
      t_override();
      t_flag();
      t_apb();
      give_verdict();
   end
endmodule
`default_nettype wire
